// >>> logic/config_and_sysref_ctrl_regs.sv
// Purpose: serial-reached configuration bank with reference-input controls
// Assumes: host frames of 16 command bits then data bytes, MSB first
// Notes:   all pins pass a three-stage sampler on the system clock
//
// Overview of operation
// R1: mode field bits 1:0; 0 normal, 3 full power-down, 1 and 2 reserved.
// R2: host writes reset values back into reserved bits on every write.
// R3: 16-bit read-only vendor code always returns a fixed value.
// R4: address-hold bit 0 freezes streaming address; else direction bit rules.
// R5: processor-enable bit 6 enables reference event processing; off after reset.
// R6: host sets receiver enable before setting processor enable.
// R7: receiver-enable bit 5 enables the reference receiver; off after reset.
// R8: zoom bit 4 selects smaller delay steps for status and delays.
// R9: host should set zoom at high clock rates with multiple windows.
// R10: four-bit delay select bits 3:0 sets delay on the reference input.
// R11: host picks delay select from the read-back edge position.
// R12: invert bit 0 inverts the reference before alignment use.
// R13: 24-bit read-only edge position status reported to the host.
// R14: direction bit 5 set increments streaming address, clear decrements; reset set.
// R15: reset loads listed values; writable fields read back last written. The code always reads cfg_a bit 7 back as 0 and bit 4 back as 1.
`timescale 1ns/1ps
`default_nettype none
module config_and_sysref_ctrl_regs
	import regbank_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = VENDOR_CODE_DEFAULT // arbitrary value
)(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// serial register port
	input  wire logic        sclk,
	input  wire logic        scs_n,
	input  wire logic        sdi,
	output logic             sdo,
	output logic             sdo_oe,
	// reference input and position status
	input  wire logic        sysref_in,
	input  wire logic [23:0] ref_edge_position,
	// configuration outputs
	output logic             power_down,
	output logic             ref_receiver_enable,
	output logic             ref_processor_enable,
	output logic             ref_window_zoom,
	output logic [3:0]       ref_delay_select,
	output logic             ref_ecl_termination,
	output logic             devclk_ecl_termination,
	// aligned reference
	output logic             ref_aligned,
	output logic             ref_event
);
	// ****************************************
	// pin sampling
	// ****************************************
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pin_q;
	logic [PIN_W-1:0] next_pin_q;

	// one sampler bank for all pins; the status word is not captured as a whole,
	// so a read may tear its bytes if the status moves during the frame
	assign pin_raw = {ref_edge_position, sysref_in, sdi, scs_n, sclk};

	// three stages; a change counts once stages two and three agree
	// reset levels match the idle pins, so no false edge follows reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_s1 <= PIN_RST;
			pin_s2 <= PIN_RST;
			pin_s3 <= PIN_RST;
			pin_q  <= PIN_RST;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_q  <= next_pin_q;
		end
	end

	// per-bit filter: keep the old level until stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_agree
			assign next_pin_q[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_q[gi];
		end
	endgenerate

	logic sclk_rise;
	logic sclk_fall;
	logic cs_active;
	logic sdi_bit;

	// edge strobes look one cycle ahead; sdi has been steady for clocks by then
	assign sclk_rise = next_pin_q[PIN_SCLK] & ~pin_q[PIN_SCLK];
	assign sclk_fall = ~next_pin_q[PIN_SCLK] & pin_q[PIN_SCLK];
	assign cs_active = ~pin_q[PIN_CS_N];
	assign sdi_bit   = pin_q[PIN_SDI];

	// ****************************************
	// registers
	// ****************************************
	// byte registers; reserved bits are kept as written
	logic [7:0] cfg_a;
	logic [7:0] op_mode;
	logic [7:0] user_serial_config;
	logic [7:0] timing_ref_control;
	logic [7:0] timing_ref_input_config;

	// ****************************************
	// serial frame engine
	// ****************************************
	// frame state, shift registers and the streaming address
	phase_t      phase;
	logic [4:0]  bit_cnt;
	logic [14:0] cmd_sr;
	logic        is_read;
	logic [14:0] addr;
	logic [7:0]  rx_sr;
	logic [7:0]  tx_sr;
	logic [14:0] step_addr;
	logic [14:0] lookup_addr;
	logic [7:0]  rd_data;
	logic        cmd_done;
	logic        byte_done;
	logic [7:0]  wr_byte;
	logic        wr_en;

	// streaming address: hold, else ascend or descend
	always_comb begin
		if (user_serial_config[USER_ADDR_HOLD])
			step_addr = addr; // R4
		else if (cfg_a[CFGA_ASCEND])
			step_addr = addr + ADDR_STEP; // R14
		else
			step_addr = addr - ADDR_STEP; // R14
	end

	// strobes for the last command bit and the last bit of each data byte
	assign cmd_done    = cs_active & sclk_rise & (phase == PH_CMD) & (bit_cnt == CMD_LAST);
	assign byte_done   = cs_active & sclk_rise & (phase == PH_DATA) & (bit_cnt == BYTE_LAST);
	assign lookup_addr = (phase == PH_CMD) ? {cmd_sr[13:0], sdi_bit} : step_addr;
	assign wr_byte     = {rx_sr[6:0], sdi_bit};
	assign wr_en       = byte_done & ~is_read;

	// frame state; deasserting select aborts any partial byte
	// a cut byte leaves its register untouched; the next select starts clean
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase   <= PH_CMD;
			bit_cnt <= CNT_ZERO;
			cmd_sr  <= 15'h0000;
			is_read <= 1'b0;
			addr    <= ADDR_CFG_A;
			rx_sr   <= BYTE_ZERO;
		end else if (!cs_active) begin
			phase   <= PH_CMD;
			bit_cnt <= CNT_ZERO;
		end else if (sclk_rise) begin
			rx_sr <= wr_byte;
			if (cmd_done) begin
				phase   <= PH_DATA;
				bit_cnt <= CNT_ZERO;
				is_read <= cmd_sr[14];
				addr    <= lookup_addr;
			end else if (byte_done) begin
				bit_cnt <= CNT_ZERO;
				addr    <= step_addr;
			end else begin
				bit_cnt <= bit_cnt + CNT_ONE;
				if (phase == PH_CMD)
					cmd_sr <= {cmd_sr[13:0], sdi_bit};
			end
		end
	end

	// read mux; unmapped addresses read zero
	// looks up the address about to be latched, so the byte is ready at that edge
	always_comb begin
		unique case (lookup_addr)
			ADDR_CFG_A:     rd_data = cfg_a;
			ADDR_OP_MODE:   rd_data = op_mode;
			ADDR_VENDOR_LO: rd_data = VENDOR_CODE[7:0]; // R3
			ADDR_VENDOR_HI: rd_data = VENDOR_CODE[15:8]; // R3
			ADDR_USER_SER:  rd_data = user_serial_config;
			ADDR_REF_CTRL:  rd_data = timing_ref_control;
			ADDR_REF_INCFG: rd_data = timing_ref_input_config;
			ADDR_POS_B0:    rd_data = pin_q[PIN_POS +: 8]; // R13
			ADDR_POS_B1:    rd_data = pin_q[PIN_POS+8 +: 8]; // R13
			ADDR_POS_B2:    rd_data = pin_q[PIN_POS+16 +: 8]; // R13
			default:        rd_data = BYTE_ZERO;
		endcase
	end

	// shift out on falling edges; byte loaded at the rising edge before
	// sdo moves only after a fall, so it is steady across the host's next rise
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_sr  <= BYTE_ZERO;
			sdo    <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= cs_active & is_read & (phase == PH_DATA);
			if (cmd_done || byte_done)
				tx_sr <= rd_data;
			else if (cs_active && sclk_fall && phase == PH_DATA) begin
				sdo   <= tx_sr[7];
				tx_sr <= {tx_sr[6:0], 1'b0};
			end
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	// reserved bits are stored as written so they read back unchanged
	// writes to read-only or unmapped addresses fall through to the default
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_a                   <= RST_CFG_A; // R15
			op_mode                 <= RST_OP_MODE; // R15
			user_serial_config      <= RST_USER_SER; // R15
			timing_ref_control      <= RST_REF_CTRL; // R15
			timing_ref_input_config <= RST_REF_INCFG; // R15
		end else if (wr_en) begin
			unique case (addr)
				ADDR_CFG_A: begin
					// reset request bit not supported here; sdo-active reads one
					cfg_a <= wr_byte;
					cfg_a[CFGA_SOFT_RESET] <= 1'b0;
					cfg_a[CFGA_SDO_ACTIVE] <= 1'b1;
				end
				ADDR_OP_MODE:   op_mode <= wr_byte; // R15
				ADDR_USER_SER:  user_serial_config <= wr_byte; // R15
				ADDR_REF_CTRL:  timing_ref_control <= wr_byte; // R15
				ADDR_REF_INCFG: timing_ref_input_config <= wr_byte; // R15
				default: ;
			endcase
		end
	end

	// ****************************************
	// mode and configuration outputs
	// ****************************************
	// reserved mode codes leave the device running
	// each output lags its register by one cycle so it leaves a flop
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			power_down             <= 1'b0;
			ref_receiver_enable    <= 1'b0;
			ref_processor_enable   <= 1'b0;
			ref_window_zoom        <= 1'b0;
			ref_delay_select       <= 4'h0;
			ref_ecl_termination    <= 1'b0;
			devclk_ecl_termination <= 1'b0;
		end else begin
			power_down             <= (op_mode[MODE_MSB:0] == MODE_POWER_DOWN); // R1
			ref_receiver_enable    <= timing_ref_control[CTRL_RECV_EN]; // R7
			ref_processor_enable   <= timing_ref_control[CTRL_PROC_EN]; // R5
			ref_window_zoom        <= timing_ref_control[CTRL_ZOOM]; // R8
			ref_delay_select       <= timing_ref_control[CTRL_SEL_MSB:0]; // R10
			ref_ecl_termination    <= timing_ref_input_config[INCFG_REF_TERM];
			devclk_ecl_termination <= timing_ref_input_config[INCFG_DEVCLK_TERM];
		end
	end

	// ****************************************
	// reference path
	// ****************************************
	// longest tap is twice the top select, inside the line depth
	logic [DLY_DEPTH-1:0] dly_line;
	logic                 ref_in_sig;
	logic [4:0]           tap;
	logic                 tapped;

	// receiver off or device powered down holds the path low
	assign ref_in_sig = (pin_q[PIN_REF] ^ timing_ref_input_config[INCFG_INVERT]) // R12
		& timing_ref_control[CTRL_RECV_EN] & (op_mode[MODE_MSB:0] != MODE_POWER_DOWN); // R7 R1
	// zoom gives one-cycle steps, otherwise two-cycle steps
	assign tap = timing_ref_control[CTRL_ZOOM] ? {1'b0, timing_ref_control[CTRL_SEL_MSB:0]}
		: {timing_ref_control[CTRL_SEL_MSB:0], 1'b0}; // R8 R10
	assign tapped = dly_line[tap];

	// one stage per clock; the tap above picks the output
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			dly_line <= '0;
		else
			dly_line <= {dly_line[DLY_DEPTH-2:0], ref_in_sig};
	end

	// events only counted while the processor is on
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_aligned <= 1'b0;
			ref_event   <= 1'b0;
		end else begin
			ref_aligned <= tapped;
			ref_event   <= timing_ref_control[CTRL_PROC_EN] & tapped & ~ref_aligned; // R5
		end
	end
endmodule
`default_nettype wire

// >>> pkg/regbank_pkg.sv
// Purpose: constants and types for the converter configuration register bank
// Assumes: byte-wide serial register map, 15-bit addresses
// Notes:   shared by the design and the bench
`default_nettype none
package regbank_pkg;
	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [14:0] ADDR_CFG_A     = 15'h0000;
	localparam logic [14:0] ADDR_OP_MODE   = 15'h0002;
	localparam logic [14:0] ADDR_VENDOR_LO = 15'h000C;
	localparam logic [14:0] ADDR_VENDOR_HI = 15'h000D;
	localparam logic [14:0] ADDR_USER_SER  = 15'h0010;
	localparam logic [14:0] ADDR_REF_CTRL  = 15'h0029;
	localparam logic [14:0] ADDR_REF_INCFG = 15'h002A;
	localparam logic [14:0] ADDR_POS_B0    = 15'h002C;
	localparam logic [14:0] ADDR_POS_B1    = 15'h002D;
	localparam logic [14:0] ADDR_POS_B2    = 15'h002E;
	localparam logic [14:0] ADDR_STEP      = 15'h0001;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_CFG_A     = 8'h30;
	localparam logic [7:0] RST_OP_MODE   = 8'h00;
	localparam logic [7:0] RST_USER_SER  = 8'h00;
	localparam logic [7:0] RST_REF_CTRL  = 8'h80;
	localparam logic [7:0] RST_REF_INCFG = 8'h00;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam logic [15:0] VENDOR_CODE_DEFAULT = 16'hA5C3; // arbitrary value
	// ****************************************
	// field positions and codes
	// ****************************************
	localparam int CFGA_SOFT_RESET = 7;
	localparam int CFGA_ASCEND     = 5;
	localparam int CFGA_SDO_ACTIVE = 4;
	localparam int USER_ADDR_HOLD  = 0;
	localparam int CTRL_PROC_EN    = 6;
	localparam int CTRL_RECV_EN    = 5;
	localparam int CTRL_ZOOM       = 4;
	localparam int CTRL_SEL_MSB    = 3;
	localparam int INCFG_DEVCLK_TERM = 2;
	localparam int INCFG_REF_TERM  = 1;
	localparam int INCFG_INVERT    = 0;
	localparam int MODE_MSB        = 1;
	localparam logic [1:0] MODE_NORMAL     = 2'h0;
	localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
	// ****************************************
	// serial frame and pin sampling
	// ****************************************
	localparam logic [4:0] CMD_LAST  = 5'h0F;  // 16 command bits
	localparam logic [4:0] BYTE_LAST = 5'h07;  // 8 data bits
	localparam logic [4:0] CNT_ZERO  = 5'h00;
	localparam logic [4:0] CNT_ONE   = 5'h01;
	localparam int PIN_W     = 28;
	localparam int PIN_SCLK  = 0;
	localparam int PIN_CS_N  = 1;
	localparam int PIN_SDI   = 2;
	localparam int PIN_REF   = 3;
	localparam int PIN_POS   = 4;
	localparam logic [PIN_W-1:0] PIN_RST = 28'h0000002;
	localparam int DLY_DEPTH = 32;
	typedef enum logic {PH_CMD = 1'b0, PH_DATA = 1'b1} phase_t;
endpackage
`default_nettype wire

// >>> tb/regbank_props.sv
// Purpose: port-level properties of the configuration bank
// Assumes: host keeps each serial clock phase 8 clocks or longer
// Notes:   bound onto every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module regbank_props (
	// clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// serial pins
	input wire logic       sclk,
	input wire logic       scs_n,
	input wire logic       sdo,
	input wire logic       sdo_oe,
	// configuration and reference
	input wire logic       power_down,
	input wire logic       ref_receiver_enable,
	input wire logic       ref_processor_enable,
	input wire logic       ref_window_zoom,
	input wire logic [3:0] ref_delay_select,
	input wire logic       ref_aligned,
	input wire logic       ref_event
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [5:0] gate_cnt;
	// cycles since path gated; 48 outlasts sync plus the longest tap
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			gate_cnt <= 6'h00;
		else if (ref_receiver_enable && !power_down)
			gate_cnt <= 6'h00;
		else if (gate_cnt != 6'h3F)
			gate_cnt <= gate_cnt + 6'h01;
	end
	a_path_gated: assert property (gate_cnt >= 6'h30 |-> !ref_aligned)
		else $error("reference passed while path gated");
	a_event_single: assert property (ref_event |=> !ref_event)
		else $error("event pulse longer than one cycle");
	a_event_needs_proc: assert property (ref_event |->
		ref_processor_enable || $past(ref_processor_enable))
		else $error("event with processor disabled");
	a_event_on_rise: assert property ($rose(ref_aligned) && ref_processor_enable
		|-> ##[0:1] ref_event)
		else $error("no event on reference rise");
	a_event_high: assert property (ref_event |-> ref_aligned)
		else $error("event while reference low");
	a_sdo_idle: assert property (scs_n [*8] |-> !sdo_oe)
		else $error("sdo driven outside a frame");
	a_sdo_on_low: assert property ($changed(sdo) && sdo_oe && $past(sdo_oe, 2) |-> !sclk)
		else $error("sdo moved while sclk high");
	a_cfg_in_frame: assert property ($changed({power_down, ref_receiver_enable,
		ref_processor_enable, ref_window_zoom, ref_delay_select}) |-> !scs_n)
		else $error("configuration changed outside a frame");
	cover property (ref_event);
	cover property ($rose(power_down));
	cover property ($fell(sdo_oe));
endmodule
bind config_and_sysref_ctrl_regs regbank_props props_u (.clock(clock), .rst(rst), .sclk(sclk),
	.scs_n(scs_n), .sdo(sdo), .sdo_oe(sdo_oe), .power_down(power_down),
	.ref_receiver_enable(ref_receiver_enable), .ref_processor_enable(ref_processor_enable),
	.ref_window_zoom(ref_window_zoom), .ref_delay_select(ref_delay_select),
	.ref_aligned(ref_aligned), .ref_event(ref_event));
`default_nettype wire

// >>> tb/spi_host_model.sv
// Purpose: serial host that configures the bank
// Assumes: 16 command bits then whole data bytes, MSB first
// Notes:   each sclk phase lasts 8 system clocks
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// system clock
	input wire logic  clock,
	// serial pins
	output logic      sclk,
	output logic      scs_n,
	output logic      sdi,
	input wire logic  sdo,
	// last byte read back
	output logic [7:0] rd_byte
);
	event got;
	// idle: deselected, clock parked low
	initial begin
		sclk = 1'b0;
		scs_n = 1'b1;
		sdi = 1'b0;
		rd_byte = 8'h00;
	end
	// data set while sclk low, sdo taken just before the fall
	task automatic bit_cycle(input logic b, output logic s);
		sdi <= b;
		repeat (8) @(posedge clock);
		sclk <= 1'b1;
		repeat (8) @(posedge clock);
		s = sdo;
		sclk <= 1'b0;
	endtask
	// whole frame; reserved bits are carried inside wd by the caller
	task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic [7:0] wd);
		logic s;
		logic [15:0] cmd;
		cmd = {rd, a};
		scs_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (int i = 15; i >= 0; i--) bit_cycle(cmd[i], s);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_cycle(wd[i], s);
				rd_byte[i] = s;
			end
			if (rd) -> got;
		end
		repeat (8) @(posedge clock);
		scs_n <= 1'b1;
		sdi <= ~sdi; // released line: no stale level
		repeat (16) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// >>> tb/test_config_and_sysref_ctrl_regs.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: serial host model drives the register port
// Notes:   read bytes are checked against a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module test_config_and_sysref_ctrl_regs;
	import regbank_pkg::*;
	logic        clock, rst, sclk, scs_n, sdi, sdo, sdo_oe, sysref_in, power_down, ref_aligned;
	logic        ref_receiver_enable, ref_processor_enable, ref_window_zoom, ref_event;
	logic        ref_ecl_termination, devclk_ecl_termination;
	logic [3:0]  ref_delay_select, sel;
	logic [23:0] ref_edge_position, pos;
	logic [7:0]  exp_q[$];
	logic [7:0]  rd_byte;
	int          num_errors = 0, comparisons = 0, cycles = 0, n1, n2;
	config_and_sysref_ctrl_regs dut_u (.clock(clock), .rst(rst), .sclk(sclk), .scs_n(scs_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sysref_in(sysref_in),
		.ref_edge_position(ref_edge_position), .power_down(power_down),
		.ref_receiver_enable(ref_receiver_enable), .ref_processor_enable(ref_processor_enable),
		.ref_window_zoom(ref_window_zoom), .ref_delay_select(ref_delay_select),
		.ref_ecl_termination(ref_ecl_termination), .devclk_ecl_termination(devclk_ecl_termination),
		.ref_aligned(ref_aligned), .ref_event(ref_event));
	spi_host_model host_u (.clock(clock), .sclk(sclk), .scs_n(scs_n), .sdi(sdi), .sdo(sdo),
		.rd_byte(rd_byte));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// streamed read; e holds the expected bytes, first byte lowest
	task automatic rx(input logic [14:0] a, input int n, input logic [23:0] e);
		for (int i = 0; i < n; i++) exp_q.push_back(e[8*i +: 8]);
		host_u.frame(1'b1, a, n, 8'h00);
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host_u.frame(1'b0, a, 1, d);
	endtask
	// cycles from a reference rise to the aligned output
	task automatic lat(output int n);
		n = 0;
		sysref_in <= 1'b1;
		while (ref_aligned !== 1'b1 && n < 90) begin
			@(posedge clock);
			n++;
		end
		check("event on rise", 1'b1, ref_event);
		sysref_in <= 1'b0;
		repeat (90) @(posedge clock);
	endtask
	// each byte read back is judged against the oldest note
	always @(host_u.got) check("read byte", exp_q.pop_front(), rd_byte);
	// hang guard, well above the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles > 40000) begin
			num_errors++;
			$display("mismatch timeout expected %0d seen %0d", 40000, cycles);
			report_and_stop();
		end
	end
	initial begin
		rst = 1'b1;
		sysref_in = 1'b0;
		ref_edge_position = 24'h000000;
		void'($urandom(32'h83BA1110));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rx(ADDR_USER_SER, 1, RST_USER_SER);
		rx(ADDR_CFG_A, 3, {RST_OP_MODE, BYTE_ZERO, RST_CFG_A});
		rx(ADDR_REF_CTRL, 2, {RST_REF_INCFG, RST_REF_CTRL});
		rx(ADDR_VENDOR_LO, 2, VENDOR_CODE_DEFAULT);
		wr(ADDR_VENDOR_LO, 8'h5A);
		rx(ADDR_VENDOR_LO, 1, VENDOR_CODE_DEFAULT[7:0]);
		rx(15'h0050, 1, BYTE_ZERO);
		// every mode code; only code 3 powers down
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_OP_MODE, 8'(m));
			check("power_down", m == 3, power_down);
			rx(ADDR_OP_MODE, 1, 8'(m));
		end
		wr(ADDR_OP_MODE, RST_OP_MODE);
		// receiver first, then processor, zoomed
		sel = 4'($urandom_range(15, 1));
		wr(ADDR_REF_CTRL, {4'hB, sel});
		check("ctrl outputs", {3'b011, sel}, {ref_processor_enable, ref_receiver_enable,
			ref_window_zoom, ref_delay_select});
		wr(ADDR_REF_CTRL, {4'hF, sel});
		rx(ADDR_REF_CTRL, 1, {4'hF, sel});
		lat(n1);
		wr(ADDR_REF_CTRL, {4'hE, sel});
		lat(n2);
		check("unzoomed delay", 24'(n1 + sel), 24'(n2));
		wr(ADDR_REF_INCFG, 8'h07);
		repeat (60) @(posedge clock);
		check("incfg outputs", 3'b111, {devclk_ecl_termination, ref_ecl_termination,
			ref_aligned});
		wr(ADDR_OP_MODE, 8'h03);
		repeat (60) @(posedge clock);
		check("aligned in power down", 1'b0, ref_aligned);
		wr(ADDR_OP_MODE, RST_OP_MODE);
		pos = 24'($urandom);
		ref_edge_position <= pos;
		repeat (8) @(posedge clock);
		rx(ADDR_POS_B0, 3, pos);
		// delay chosen from the status byte just read back
		sel = pos[19:16];
		wr(ADDR_REF_CTRL, {4'hE, sel});
		check("delay select", sel, ref_delay_select);
		// descending, then held address
		wr(ADDR_CFG_A, 8'h10);
		rx(ADDR_REF_INCFG, 2, {8'h00, 4'hE, sel, 8'h07});
		wr(ADDR_USER_SER, 8'h01);
		rx(ADDR_REF_INCFG, 2, 24'h000707);
		// reset in mid-run brings back the reference control, input config and address hold values
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rx(ADDR_REF_CTRL, 2, {RST_REF_INCFG, RST_REF_CTRL});
		check("outputs after reset", 24'h000000, {power_down, ref_processor_enable,
			ref_receiver_enable, ref_window_zoom, ref_delay_select, ref_aligned});
		check("notes left", 24'h000000, 24'(exp_q.size()));
		report_and_stop();
	end
endmodule
`default_nettype wire
